// File: shift_reg_pkg.sv
// shared constants and types for the four-stage load/shift register
`default_nettype none
package shift_reg_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int STAGE_COUNT = 4;
   localparam int PIN_COUNT = 8;
   // ----------------------------------------
   // input bundle bit positions after synchronising
   // ----------------------------------------
   localparam int PIN_CLK = 0;
   localparam int PIN_SERIAL = 1;
   localparam int PIN_SELECT = 2;
   localparam int PIN_DRIVE = 3;
   localparam int PIN_PAR_LSB = 4;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 4'h0;
   localparam logic [PIN_COUNT-1:0] PIN_RESET = 8'h00;
   localparam logic OE_N_RESET = 1'h1;
   // ----------------------------------------
   // modes of the select input
   // ----------------------------------------
   typedef enum logic {
      MODE_SHIFT = 1'h0,
      MODE_LOAD = 1'h1
   } mode_type;
endpackage
`default_nettype wire

// File: pin_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // pins and filtered result
   input wire logic [WIDTH-1:0] rawIn,
   output logic [WIDTH-1:0] cleanOut
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] second_ff;
   logic [WIDTH-1:0] third_ff;
   logic [WIDTH-1:0] clean_ff;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] nxt_clean;

   if (WIDTH < 1) begin : gWidthCheck
      $error("pin_sync: WIDTH must be at least one");
   end

   // only the second and third flops are compared; the first may be metastable
   assign agree = ~(second_ff ^ third_ff);
   assign nxt_clean = (agree & second_ff) | (~agree & clean_ff);
   assign cleanOut = clean_ff;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         meta_ff <= RESET_VALUE;
         second_ff <= RESET_VALUE;
         third_ff <= RESET_VALUE;
         clean_ff <= RESET_VALUE;
      end else begin
         meta_ff <= rawIn;
         second_ff <= meta_ff;
         third_ff <= second_ff;
         clean_ff <= nxt_clean;
      end
   end
endmodule
`default_nettype wire

// File: load_shift_register.sv
// four-stage register with parallel load, right shift and disable-able outputs
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - four stages, each with its own parallel input and its own output
// - select high copies each parallel input into its own stage
// - stages change only on a falling edge of the device clock pin
// - select high keeps the serial input out of every stage
// - select low shifts: serial into stage zero, each stage takes its predecessor
// - without a falling clock edge every stage holds its value
// - drive enable high drives the stored values onto the outputs
// - drive enable low floats all outputs regardless of the clock
// - floating the outputs does not stop loading or shifting
module load_shift_register (
   // system clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // device control pins
   input wire logic deviceClk,
   input wire logic load_shift_select,
   input wire logic output_drive_enable,
   input wire logic serial_in,
   // parallel data pins
   input wire logic parallelIn0,
   input wire logic parallelIn1,
   input wire logic parallelIn2,
   input wire logic parallelIn3,
   // stage outputs
   output logic stageOut0,
   output logic stageOut1,
   output logic stageOut2,
   output logic stageOut3,
   // output enable, low while driving
   output logic stageOutOeN
);
   import shift_reg_pkg::*;

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   // the parallel pins must sit inside the synchroniser bundle or stages read the wrong pins
   if (PIN_PAR_LSB + STAGE_COUNT > PIN_COUNT) begin : gPinCheck
      $error("load_shift_register: parallel pins do not fit the pin bundle");
   end

   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   // every pin goes through the same depth so data stays aligned with the clock edge
   logic [PIN_COUNT-1:0] rawPins;
   logic [PIN_COUNT-1:0] cleanPins;

   assign rawPins[PIN_CLK] = deviceClk;
   assign rawPins[PIN_SERIAL] = serial_in;
   assign rawPins[PIN_SELECT] = load_shift_select;
   assign rawPins[PIN_DRIVE] = output_drive_enable;
   assign rawPins[PIN_PAR_LSB+0] = parallelIn0;
   assign rawPins[PIN_PAR_LSB+1] = parallelIn1;
   assign rawPins[PIN_PAR_LSB+2] = parallelIn2;
   assign rawPins[PIN_PAR_LSB+3] = parallelIn3;

   pin_sync #(
      .WIDTH(PIN_COUNT),
      .RESET_VALUE(PIN_RESET)
   ) uPinSync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .rawIn(rawPins),
      .cleanOut(cleanPins)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic clkPrev_ff;
   logic fallEdge;
   mode_type mode;
   logic serialBit;
   logic [STAGE_COUNT-1:0] parallelBits;
   logic [STAGE_COUNT-1:0] stage_ff;
   logic [STAGE_COUNT-1:0] nxt_stage;
   logic oeN_ff;
   logic nxt_oeN;

   // clock reset low so the release of reset never fakes a falling edge
   assign fallEdge = clkPrev_ff & ~cleanPins[PIN_CLK];
   assign mode = mode_type'(cleanPins[PIN_SELECT]);
   assign serialBit = cleanPins[PIN_SERIAL];
   assign parallelBits = cleanPins[PIN_PAR_LSB +: STAGE_COUNT];

   // ----------------------------------------
   // next stage values
   // ----------------------------------------
   // left shift is purely outside wiring into the parallel inputs, nothing here
   for (genvar i = 0; i < STAGE_COUNT; i++) begin : gStage
      logic shiftSource;
      logic modeValue;
      if (i == 0) begin : gFirst
         assign shiftSource = serialBit;
      end else begin : gLater
         assign shiftSource = stage_ff[i-1];
      end
      // load path never looks at the serial bit
      assign modeValue = (mode == MODE_LOAD) ? parallelBits[i] : shiftSource;
      assign nxt_stage[i] = fallEdge ? modeValue : stage_ff[i];
   end

   // enable does not gate the stage update, only the drive
   assign nxt_oeN = ~cleanPins[PIN_DRIVE];

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // the system reset clears the stages for a clean simulation; the part itself has no reset pin
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         clkPrev_ff <= PIN_RESET[PIN_CLK];
         stage_ff <= STAGE_RESET;
         oeN_ff <= OE_N_RESET;
      end else begin
         clkPrev_ff <= cleanPins[PIN_CLK];
         stage_ff <= nxt_stage;
         oeN_ff <= nxt_oeN;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign stageOut0 = stage_ff[0];
   assign stageOut1 = stage_ff[1];
   assign stageOut2 = stage_ff[2];
   assign stageOut3 = stage_ff[3];
   assign stageOutOeN = oeN_ff;
endmodule
`default_nettype wire

// File: lsr_assertions.sv
// port checker for the four-stage load/shift register
`timescale 1ns/100ps
`default_nettype none
module lsr_checker (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic deviceClk,
   input wire logic load_shift_select,
   input wire logic output_drive_enable,
   input wire logic serial_in,
   input wire logic parallelIn0,
   input wire logic parallelIn1,
   input wire logic parallelIn2,
   input wire logic parallelIn3,
   input wire logic stageOut0,
   input wire logic stageOut1,
   input wire logic stageOut2,
   input wire logic stageOut3,
   input wire logic stageOutOeN
);
   wire [3:0] q = {stageOut3, stageOut2, stageOut1, stageOut0};
   wire [3:0] p = {parallelIn3, parallelIn2, parallelIn1, parallelIn0};
   logic clkD_ff;
   logic [4:0] fellHist_ff;
   // a fall seen straight out of reset is not an edge
   wire fall = clkD_ff & ~deviceClk;
   wire sel = load_shift_select;
   always_ff @(posedge clk_sys) begin
      clkD_ff <= nrst & deviceClk;
      fellHist_ff <= nrst ? {fellHist_ff[3:0], fall} : 5'h00;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_shift_stage_zero: assert property (fall && !sel |-> ##5 stageOut0 == $past(serial_in, 5))
      else $error("stage zero missed the serial bit");
   a_shift_moves_on: assert property (fall && !sel |-> ##5 q[3:1] == $past(q[2:0], 5))
      else $error("stages did not move up");
   a_load_copies: assert property (fall && sel |-> ##5 q == $past(p, 5))
      else $error("load mismatch");
   a_float_keeps_run: assert property (fall && sel && !output_drive_enable |-> ##5 q == $past(p, 5))
      else $error("load lost while floated");
   a_hold_no_edge: assert property ($changed(q) |-> fellHist_ff[4])
      else $error("stage changed without a fall");
   a_stage_not_early: assert property (fall |-> ##4 $stable(q))
      else $error("stage changed early");
   a_oe_follows: assert property ($changed(output_drive_enable) |-> ##5 stageOutOeN == !$past(output_drive_enable, 5))
      else $error("enable not followed");
   a_oe_not_early: assert property ($changed(output_drive_enable) |-> ##4 $stable(stageOutOeN))
      else $error("enable changed early");
endmodule
bind load_shift_register lsr_checker chk (.*);
`default_nettype wire

// File: lsr_partner.sv
// surrounding logic: bus resolution and left-shift feedback
`timescale 1ns/100ps
`default_nettype none
module lsr_partner (
   input wire logic leftMode,
   input wire logic leftSerial,
   input wire logic [3:0] userPar,
   input wire logic [3:0] q,
   input wire logic oeN,
   output wire logic [3:0] bus,
   output wire logic [3:0] par
);
   assign bus = oeN ? 4'hz : q;
   // feedback comes off the bus, so a floated bus feeds z back
   assign par = leftMode ? {leftSerial, bus[3:1]} : userPar;
endmodule
`default_nettype wire

// File: bidir_shift_register_4bit_test.sv
// self-checking bench for the load/shift register
`timescale 1ns/100ps
`default_nettype none
module bidir_shift_register_4bit_test;
   logic clk_sys = 0;
   logic nrst = 0;
   logic dclk = 1;
   logic sel = 0;
   logic ode = 1;
   logic serialPin = 0;
   logic leftMode = 0;
   logic [3:0] userPar = 4'h0;
   wire [3:0] q;
   wire [3:0] par;
   wire [3:0] bus;
   wire oeN;
   int err_total = 0;
   int checks_done = 0;
   always #2.5 clk_sys = ~clk_sys;
   load_shift_register dut (.clk_sys(clk_sys), .nrst(nrst), .deviceClk(dclk), .load_shift_select(sel),
      .output_drive_enable(ode), .serial_in(serialPin), .parallelIn0(par[0]), .parallelIn1(par[1]),
      .parallelIn2(par[2]), .parallelIn3(par[3]), .stageOut0(q[0]), .stageOut1(q[1]),
      .stageOut2(q[2]), .stageOut3(q[3]), .stageOutOeN(oeN));
   lsr_partner far (.leftMode(leftMode), .leftSerial(serialPin), .userPar(userPar), .q(q), .oeN(oeN),
      .bus(bus), .par(par));
   task automatic chk(input logic [3:0] exp);
      checks_done++;
      if (bus !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t bus %h expected %h", $time, bus, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // pins settle 8 cycles each side of the fall, wider than the sampling window
   task automatic step(input logic s, input logic b, input logic [3:0] d);
      sel <= s;
      serialPin <= b;
      userPar <= d;
      cyc(8);
      dclk <= 0;
      cyc(8);
      dclk <= 1;
      cyc(8);
   endtask
   task automatic load_ignores_serial;
      step(1, 1, 4'ha);
      chk(4'ha);
      step(1, 0, 4'h5);
      chk(4'h5);
   endtask
   task automatic shift_right;
      step(0, 1, 4'hf);
      chk(4'hb);
      step(0, 0, 4'hf);
      chk(4'h6);
   endtask
   task automatic shift_left;
      leftMode <= 1;
      step(1, 1, 4'h0);
      chk(4'hb);
      step(1, 0, 4'h0);
      chk(4'h5);
      leftMode <= 0;
   endtask
   task automatic float_run;
      ode <= 0;
      cyc(8);
      chk(4'hz);
      step(1, 0, 4'h3);
      step(0, 1, 4'h0);
      chk(4'hz);
      ode <= 1;
      cyc(8);
      chk(4'h7);
   endtask
   task automatic hold_no_edge;
      userPar <= 4'h8;
      sel <= 1;
      cyc(20);
      chk(4'h7);
      sel <= 0;
      cyc(20);
      chk(4'h7);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      cyc(12);
      nrst <= 1;
      cyc(8);
      load_ignores_serial();
      shift_right();
      shift_left();
      float_run();
      hold_no_edge();
      tally_and_finish();
   end
endmodule
`default_nettype wire
